// *** design/ptb_divider.sv ***
// Eighteen-stage divider chain with selectable rollover taps
`timescale 1ns/1ps
module ptb_divider
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic [ptb_pkg::PTB_RATE_W-1:0] i_rate,
  output logic o_rollover,
  output logic [ptb_pkg::PTB_CNT_W-1:0] o_count
);
  import ptb_pkg::*;

  logic [PTB_CNT_W-1:0] inc;
  logic [PTB_NRATES-1:0] hit;

  // Counter value after one more reference edge
  assign inc = o_count + {{(PTB_CNT_W-1){1'b0}}, 1'b1};

  // Tap bit rising marks a rollover: first at half period
  generate
    for (genvar g = 0; g < PTB_NRATES; g++)
    begin : g_tap
      localparam int TAP = $clog2(PTB_DIVISOR[g]) - 1;
      assign hit[g] = i_tick & ~o_count[TAP] & inc[TAP];
    end
  endgenerate

  assign o_rollover = hit[i_rate];

  // Counter held at zero while cleared
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b || i_clear)
      o_count <= '0;
    else if (i_tick)
      o_count <= inc;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  cnt_cleared_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clear |=> o_count == '0)
    else $error("divider not zero after clear");

  cnt_steps_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (!i_clear && i_tick) |=> o_count == $past(inc))
    else $error("divider missed a reference edge");

endmodule : ptb_divider

// *** design/ptb_pkg.sv ***
// Shared constants and types for the periodic timebase block
package ptb_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned PTB_CNT_W = 18;
  localparam int unsigned PTB_RATE_W = 3;
  localparam int unsigned PTB_NRATES = 8;
  localparam int unsigned PTB_ADDR_W = 8;
  localparam int unsigned PTB_DATA_W = 32;
  localparam int unsigned PTB_EVT_W = 2;

  // ------------------------------------------------------------
  // Reference clock divisor per rate select code
  // ------------------------------------------------------------
  localparam int unsigned PTB_DIVISOR [PTB_NRATES] = '{
    262144, 131072, 65536, 32768, 64, 32, 16, 8
  };

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [PTB_ADDR_W-1:0] PTB_OFF_CTRL = 8'h00;
  localparam logic [PTB_ADDR_W-1:0] PTB_OFF_EVT_STAT = 8'h04;
  localparam logic [PTB_ADDR_W-1:0] PTB_OFF_EVT_MASK = 8'h08;

  // ------------------------------------------------------------
  // Control register field positions
  // ------------------------------------------------------------
  localparam int unsigned PTB_BIT_FLAG = 7;
  localparam int unsigned PTB_RATE_LSB = 4;
  localparam int unsigned PTB_BIT_ACK = 3;
  localparam int unsigned PTB_BIT_IE = 2;
  localparam int unsigned PTB_BIT_RUN = 1;

  // Event status bit positions
  localparam int unsigned PTB_EVT_ROLL = 0;
  localparam int unsigned PTB_EVT_REFUSE = 1;

  // ------------------------------------------------------------
  // Types and reset values
  // ------------------------------------------------------------
  typedef struct packed {
    logic irq_en;
    logic [PTB_RATE_W-1:0] rate;
    logic run;
  } ptb_ctrl_t;

  localparam ptb_ctrl_t PTB_CTRL_RST = '{irq_en: 1'h0, rate: 3'h0, run: 1'h0};
  localparam logic [PTB_EVT_W-1:0] PTB_EVT_RST = 2'h0;
  localparam logic [PTB_DATA_W-1:0] PTB_RD_ZERO = 32'h0000_0000;

endpackage : ptb_pkg

// *** design/ptb_sync.sv ***
// Two-stage synchroniser for the oscillator reference clock pin
`timescale 1ns/1ps
module ptb_sync
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_async,
  output logic o_level
);
  import ptb_pkg::*;

  logic meta;

  // First stage feeds only the second
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      meta <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      meta <= i_async;
      o_level <= meta;
    end
  end

endmodule : ptb_sync

// *** design/ptb_timebase.sv ***
// Periodic timebase with APB control register and interrupt
// ------------------------------------------------------------
// What this block does
// - Disabled counter held zero, enabled counts edges
// - Eighteen stages, eight selectable taps
// - Tap overflow sets periodic flag
// - Flag with irq enable raises interrupt
// - First event half period, then exact
// - Rate codes map to documented divisors
// - Flag read-only, set only by rollover
// - Acknowledge write-one clears flag, reads zero
// - Reset clears run and irq enables
// - Wait: counting continues, register inaccessible
// - Stop: runs only if oscillator kept
// - Stop: register inaccessible to CPU
// ------------------------------------------------------------
`timescale 1ns/1ps
module ptb_timebase
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ptb_pkg::PTB_ADDR_W-1:0] i_paddr,
  input wire logic [ptb_pkg::PTB_DATA_W-1:0] i_pwdata,
  output logic [ptb_pkg::PTB_DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_osc_reference_clock,
  input wire logic i_wait_mode,
  input wire logic i_stop_mode,
  input wire logic i_stop_osc_enable,
  output logic o_irq
);
  import ptb_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  ptb_ctrl_t ctrl;
  logic periodic_flag;
  logic [PTB_EVT_W-1:0] evt_stat;
  logic [PTB_EVT_W-1:0] evt_mask;
  logic osc_level;
  logic osc_prev;

  // ------------------------------------------------------------
  // Combinational nets
  // ------------------------------------------------------------
  logic osc_tick;
  logic active;
  logic rollover;
  logic [PTB_CNT_W-1:0] count;
  logic cpu_blocked;
  logic setup_ph;
  logic access_ph;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_mask;
  logic mapped;
  logic refused;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic ack_write;
  logic [PTB_DATA_W-1:0] ctrl_rd;
  logic [PTB_DATA_W-1:0] rd_mux;
  logic [PTB_EVT_W-1:0] evt_new;
  logic [PTB_EVT_W-1:0] next_evt_stat;
  ptb_ctrl_t next_ctrl;
  logic next_flag;

  // ------------------------------------------------------------
  // Reference clock capture
  // ------------------------------------------------------------
  ptb_sync u_osc_sync
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_async(i_osc_reference_clock),
    .o_level(osc_level)
  );

  // Previous synchronised level for edge detection
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      osc_prev <= 1'b0;
    else
      osc_prev <= osc_level;
  end

  // Count only while enabled and oscillator alive in stop
  assign osc_tick = osc_level & ~osc_prev;
  assign active = ctrl.run & ~(i_stop_mode & ~i_stop_osc_enable);

  // ------------------------------------------------------------
  // Divider chain
  // ------------------------------------------------------------
  ptb_divider u_div
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_clear(~ctrl.run),
    .i_tick(osc_tick & active),
    .i_rate(ctrl.rate),
    .o_rollover(rollover),
    .o_count(count)
  );

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign cpu_blocked = i_wait_mode | i_stop_mode;
  assign setup_ph = i_psel & ~i_penable;
  assign access_ph = i_psel & i_penable;
  assign sel_ctrl = (i_paddr == PTB_OFF_CTRL);
  assign sel_stat = (i_paddr == PTB_OFF_EVT_STAT);
  assign sel_mask = (i_paddr == PTB_OFF_EVT_MASK);
  assign mapped = sel_ctrl | sel_stat | sel_mask;
  assign refused = ~mapped | cpu_blocked;
  assign wr_ok = access_ph & i_pwrite & ~refused;
  assign wr_ctrl = wr_ok & sel_ctrl;
  assign wr_stat = wr_ok & sel_stat;
  assign wr_mask = wr_ok & sel_mask;
  assign ack_write = wr_ctrl & i_pwdata[PTB_BIT_ACK];

  // Zero wait states; refused accesses flag an error
  assign o_pready = 1'b1;
  assign o_pslverr = access_ph & refused;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Control image; acknowledge bit always reads zero
  always_comb
  begin
    ctrl_rd = PTB_RD_ZERO;
    ctrl_rd[PTB_BIT_FLAG] = periodic_flag;
    ctrl_rd[PTB_RATE_LSB +: PTB_RATE_W] = ctrl.rate;
    ctrl_rd[PTB_BIT_IE] = ctrl.irq_en;
    ctrl_rd[PTB_BIT_RUN] = ctrl.run;
  end

  assign rd_mux = refused ? PTB_RD_ZERO :
                  sel_ctrl ? ctrl_rd :
                  sel_stat ? {{(PTB_DATA_W-PTB_EVT_W){1'b0}}, evt_stat} :
                  {{(PTB_DATA_W-PTB_EVT_W){1'b0}}, evt_mask};

  // Read data captured in the setup cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      o_prdata <= PTB_RD_ZERO;
    else if (setup_ph)
      o_prdata <= rd_mux;
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  // Flag is not writable; only enables and rate store
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl)
    begin
      next_ctrl.irq_en = i_pwdata[PTB_BIT_IE];
      next_ctrl.rate = i_pwdata[PTB_RATE_LSB +: PTB_RATE_W];
      next_ctrl.run = i_pwdata[PTB_BIT_RUN];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      ctrl <= PTB_CTRL_RST;
    else
      ctrl <= next_ctrl;
  end

  // ------------------------------------------------------------
  // Periodic flag
  // ------------------------------------------------------------
  // Rollover set wins over acknowledge clear
  assign next_flag = rollover | (periodic_flag & ~ack_write);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      periodic_flag <= 1'b0;
    else
      periodic_flag <= next_flag;
  end

  // ------------------------------------------------------------
  // Event status and mask
  // ------------------------------------------------------------
  // Sticky events, write one to clear, new event wins
  always_comb
  begin
    evt_new = PTB_EVT_RST;
    evt_new[PTB_EVT_ROLL] = rollover;
    evt_new[PTB_EVT_REFUSE] = access_ph & refused;
    next_evt_stat = evt_stat;
    if (wr_stat)
      next_evt_stat = evt_stat & ~i_pwdata[PTB_EVT_W-1:0];
    next_evt_stat = next_evt_stat | evt_new;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      evt_stat <= PTB_EVT_RST;
      evt_mask <= PTB_EVT_RST;
    end
    else
    begin
      evt_stat <= next_evt_stat;
      if (wr_mask)
        evt_mask <= i_pwdata[PTB_EVT_W-1:0];
    end
  end

  // Flag path plus masked sticky events
  assign o_irq = (periodic_flag & ctrl.irq_en) | (|(evt_stat & evt_mask));

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence ack_write_s;
    access_ph && i_pwrite && sel_ctrl && !cpu_blocked && i_pwdata[PTB_BIT_ACK];
  endsequence

  sequence blocked_access_s;
    access_ph && cpu_blocked;
  endsequence

  counter_held_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !ctrl.run |=> count == '0)
    else $error("counter not held while disabled");

  roll_sets_flag_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    rollover |=> periodic_flag)
    else $error("rollover did not set flag");

  irq_follows_flag_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (periodic_flag && ctrl.irq_en) |-> o_irq)
    else $error("interrupt missing for pending flag");

  flag_source_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    $rose(periodic_flag) |-> $past(rollover))
    else $error("flag set without rollover");

  ack_clears_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (ack_write_s and !rollover) |=> !periodic_flag)
    else $error("acknowledge did not clear flag");

  ack_reads_zero_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (access_ph && !i_pwrite && sel_ctrl) |-> !o_prdata[PTB_BIT_ACK])
    else $error("acknowledge bit read as one");

  reset_state_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> (!ctrl.run && !ctrl.irq_en && count == '0))
    else $error("enables not cleared by reset");

  blocked_write_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    blocked_access_s |-> o_pslverr ##1 $stable(ctrl))
    else $error("register reached in low power mode");

  stop_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_stop_mode && !i_stop_osc_enable && ctrl.run) |=> $stable(count))
    else $error("counter moved in stop without oscillator");

  set_wins_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (ack_write_s and rollover) |=> periodic_flag)
    else $error("rollover lost to acknowledge");

  // ------------------------------------------------------------
  // Bus, event and low-power checks
  // ------------------------------------------------------------
  sequence refused_access_s;
    access_ph && refused;
  endsequence

  sequence blocked_read_s;
    (setup_ph && cpu_blocked) ##1 (access_ph && !i_pwrite);
  endsequence

  blocked_read_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    blocked_read_s |-> o_prdata == PTB_RD_ZERO)
    else $error("register read in low power mode");

  refused_event_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    refused_access_s |=> evt_stat[PTB_EVT_REFUSE])
    else $error("refused access not recorded");

  clean_access_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (access_ph && !refused) |-> !o_pslverr)
    else $error("error on an accessible register");

  flag_clear_src_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    $fell(periodic_flag) |-> $past(ack_write))
    else $error("flag cleared without acknowledge");

  wait_counts_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_wait_mode && !i_stop_mode && ctrl.run && osc_tick) |=> count != $past(count))
    else $error("counter stalled in wait mode");

  stop_no_roll_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_stop_mode && !i_stop_osc_enable) |-> !rollover)
    else $error("rollover in stop without oscillator");

  roll_event_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    rollover |=> evt_stat[PTB_EVT_ROLL])
    else $error("rollover event not recorded");

  evt_sticky_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (evt_stat[PTB_EVT_ROLL] && !wr_stat) |=> evt_stat[PTB_EVT_ROLL])
    else $error("rollover event lost without clear");

endmodule : ptb_timebase

// *** sim/test_ptb_timebase.sv ***
// Self-checking bench for the periodic timebase block
`timescale 1ns/1ps
module test_ptb_timebase;
  import ptb_pkg::*;

  typedef struct packed
  {
    logic rd;
    logic err;
    logic [31:0] data;
  } ptb_note_t;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc = 1'b0;
  logic wait_m = 1'b0;
  logic stop_m = 1'b0;
  logic stop_osc = 1'b0;
  logic irq;
  logic [2:0] osc_cnt = 3'h0;
  int n_edge = 0;
  int cyc = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h2455_d1a7;
  ptb_note_t exp_q[$];
  ptb_note_t note;

  ptb_timebase dut
  (
    .i_clk_sys(clk),
    .i_rst_b(rst_b),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_osc_reference_clock(osc),
    .i_wait_mode(wait_m),
    .i_stop_mode(stop_m),
    .i_stop_osc_enable(stop_osc),
    .o_irq(irq)
  );

  // System clock, 100 ns period
  always #50 clk = ~clk;

  // Reference clock of eight system cycles, rises counted
  always @(posedge clk)
  begin
    osc_cnt <= osc_cnt + 3'h1;
    osc <= osc_cnt[2];
    if (osc_cnt == 3'h4)
      n_edge <= n_edge + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // Bus monitor: each completed access is compared with the oldest note
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check(32'(pslverr), 32'(note.err), "slave error");
      if (note.rd)
        check(prdata, note.data, "read data");
    end
  end

  // One APB transfer; upper write bits are random filler
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    ptb_note_t n;
    logic [31:0] r;
    r = $random(seed);
    n.rd = !wr;
    n.err = ee;
    n.data = ed;
    exp_q.push_back(n);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {r[31:8], d[7:0]};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk); // Idle edge keeps each strobe single per step
  endtask : apb

  task automatic expect_irq(input logic v);
    @(negedge clk);
    check(32'(irq), 32'(v), "irq level");
    @(posedge clk);
  endtask : expect_irq

  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    check(32'(irq), 32'h0000_0001, "irq arrival");
  endtask : wait_irq

  // Enable at one rate, time first and second event, then acknowledge
  task automatic rate_run(input int code);
    logic [31:0] cw;
    int e0;
    int div;
    div = PTB_DIVISOR[code];
    cw = 32'h0000_0006 | 32'(code << 4);
    apb(1'b1, PTB_OFF_CTRL, cw, 0, 1'b0);
    e0 = n_edge;
    wait_irq(div * 8 + 100);
    check(32'(n_edge - e0 >= div / 2 - 1 && n_edge - e0 <= div / 2 + 1), 1, "half");
    e0 = n_edge;
    apb(1'b1, PTB_OFF_CTRL, cw | 32'h0000_0008, 0, 1'b0);
    expect_irq(1'b0);
    wait_irq(div * 8 + 100);
    check(32'(n_edge - e0), 32'(div), "period");
    apb(1'b1, PTB_OFF_CTRL, cw, 0, 1'b0);
    apb(1'b0, PTB_OFF_CTRL, 0, cw | 32'h0000_0080, 1'b0);
    apb(1'b1, PTB_OFF_CTRL, 0, 0, 1'b0);
    expect_irq(1'b0);
    apb(1'b1, PTB_OFF_CTRL, 32'h0000_0088, 0, 1'b0);
    apb(1'b0, PTB_OFF_CTRL, 0, 0, 1'b0);
    $display("test rate %0d done", code);
  endtask : rate_run

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 3; i++)
      apb(1'b0, 8'(i * 4), 0, 0, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, PTB_OFF_CTRL, 32'(c << 4) | 32'h0000_0004, 0, 1'b0);
      apb(1'b0, PTB_OFF_CTRL, 0, 32'(c << 4) | 32'h0000_0004, 1'b0);
    end
    apb(1'b1, PTB_OFF_CTRL, 0, 0, 1'b0);
    $display("test rate codes done");
    for (int c = 4; c < 8; c++)
      rate_run(c);
    // Stop without oscillator: frozen and shut; then oscillator kept
    apb(1'b1, PTB_OFF_CTRL, 32'h0000_0076, 0, 1'b0);
    stop_m <= 1'b1;
    repeat (200) @(posedge clk);
    expect_irq(1'b0);
    apb(1'b0, PTB_OFF_CTRL, 0, 0, 1'b1);
    apb(1'b1, PTB_OFF_CTRL, 0, 0, 1'b1);
    stop_osc <= 1'b1;
    wait_irq(300);
    stop_m <= 1'b0;
    stop_osc <= 1'b0;
    $display("test stop done");
    // Wait mode: counting goes on, register refused
    apb(1'b1, PTB_OFF_CTRL, 32'h0000_0008, 0, 1'b0);
    apb(1'b1, PTB_OFF_CTRL, 32'h0000_0066, 0, 1'b0);
    wait_m <= 1'b1;
    apb(1'b1, PTB_OFF_CTRL, 0, 0, 1'b1);
    apb(1'b0, PTB_OFF_CTRL, 0, 0, 1'b1);
    wait_irq(300);
    wait_m <= 1'b0;
    apb(1'b1, PTB_OFF_CTRL, 32'h0000_0008, 0, 1'b0);
    $display("test wait done");
    // Event status, mask and unmapped access
    apb(1'b1, PTB_OFF_EVT_STAT, 32'h0000_0003, 0, 1'b0);
    apb(1'b0, PTB_OFF_EVT_STAT, 0, 0, 1'b0);
    apb(1'b0, 8'h0C, 0, 0, 1'b1);
    apb(1'b0, PTB_OFF_EVT_STAT, 0, 32'h0000_0002, 1'b0);
    apb(1'b1, PTB_OFF_EVT_MASK, 32'h0000_0002, 0, 1'b0);
    expect_irq(1'b1);
    apb(1'b0, PTB_OFF_EVT_MASK, 0, 32'h0000_0002, 1'b0);
    apb(1'b1, PTB_OFF_EVT_STAT, 32'h0000_0002, 0, 1'b0);
    expect_irq(1'b0);
    apb(1'b1, PTB_OFF_EVT_MASK, 0, 0, 1'b0);
    $display("test events done");
    // Acknowledge on the rollover edge keeps the flag, then reset in mid-run
    apb(1'b1, PTB_OFF_CTRL, 32'h0000_0076, 0, 1'b0);
    wait_irq(200);
    repeat (61) @(posedge clk);
    apb(1'b1, PTB_OFF_CTRL, 32'h0000_007e, 0, 1'b0);
    expect_irq(1'b1);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    expect_irq(1'b0);
    apb(1'b0, PTB_OFF_CTRL, 0, 0, 1'b0);
    repeat (2) @(posedge clk);
    $display("test reset done");
    report_and_stop();
  end
endmodule : test_ptb_timebase
